// file: msd_pkg.sv
// Package: constants shared by the memory select decode block
package msd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and standby timing
    localparam int CLK_MHZ = 200;
    localparam int STBY_NS = 70;
    localparam int STBY_CYC = (STBY_NS * CLK_MHZ + 999) / 1000;
    localparam int STBY_CNT_W = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Layout of the synchronised pin vector
    localparam int S_ADDR = 0;
    localparam int S_DATA = 20;
    localparam int S_WR = 36;
    localparam int S_RD = 37;
    localparam int S_FETCH = 38;
    localparam int S_HRST = 39;
    localparam int S_PDN = 40;
    localparam int S_ABC = 41;
    localparam int S_PD = 65;
    localparam int S_PF = 69;
    localparam int S_RDY = 77;
    localparam int S_EXT = 78;
    localparam int SYNC_W = 79;
    localparam int BUS_W = 82;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration space offsets (low address byte)
    localparam logic [7:0] OFF_PAGE = 8'he0;
    localparam logic [7:0] OFF_MAP = 8'h02;
    localparam logic [7:0] OFF_PWR0 = 8'hb0;
    localparam logic [7:0] OFF_PWR2 = 8'hb4;
    localparam logic [7:0] OFF_ID0 = 8'hf0;
    localparam logic [7:0] OFF_ID1 = 8'hf1;
    localparam logic [7:0] OFF_CELL_A = 8'h20;
    localparam logic [7:0] OFF_CELL_B = 8'h21;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and field positions
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] MAP_RST = 8'h0c;
    localparam logic [7:0] PWR0_RST = 8'h00;
    localparam logic [7:0] PWR2_RST = 8'h00;
    localparam int PWR0_FAST = 3;
    localparam int MAP_SRAM_FETCH = 0;
    localparam int MAP_SEC_FETCH = 1;
    localparam int MAP_PRI_FETCH = 2;
    localparam int MAP_SEC_DATA = 3;
    localparam int MAP_PRI_DATA = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Default decode windows; the secondary and SRAM limits keep a window inside its physical sector, the primary limit is zero
    localparam logic [255:0] PRI_BASE_DEF = {16{16'h8000}};
    localparam logic [255:0] PRI_MASK_DEF = {16{16'h8000}};
    localparam logic [127:0] PRI_PAGE_DEF = 128'h0f0e0d0c0b0a09080706050403020100;
    localparam logic [127:0] PRI_PMASK_DEF = {16{8'hff}};
    localparam logic [63:0] SEC_BASE_DEF = 64'h7000600050004000;
    localparam logic [63:0] SEC_MASK_DEF = {4{16'hf000}};
    localparam logic [15:0] PRI_LIMIT = 16'h0000;
    localparam logic [15:0] SEC_LIMIT = 16'hc000;
    localparam logic [15:0] SRAM_LIMIT = 16'h8000;
    localparam logic [15:0] SRAM_BASE_DEF = 16'h0000;
    localparam logic [15:0] SRAM_MASK_DEF = 16'he000;
    localparam logic [15:0] CFG_BASE_DEF = 16'h2000;
    localparam logic [15:0] IO_MASK_DEF = 16'hff00;
    localparam logic [31:0] PER_BASE_DEF = 32'h22002100;
    localparam logic [15:0] JTAG_BASE_DEF = 16'h2300;
    localparam logic [127:0] ECS_BASE_DEF =
        128'h37003600350034003300320031003000;

endpackage : msd_pkg

// file: msd_memory_select.sv
// Memory select decode, paging, mapping and logic-array input bus
//
// Overview of operation
// R01 - Flash windows never exceed physical sector size (PRI_LIMIT is zero, so primary windows are not limited)
// R02 - Primary sector windows never overlap each other
// R03 - Secondary sector windows never overlap each other
// R04 - Secondary sector wins over overlapping primary
// R05 - SRAM and I/O exclusive, beat flash
// R06 - Three priority levels, higher overrides lower
// R07 - Mapping register places memories per space
// R08 - Host writes 0Ch for separate spaces
// R09 - Map bits 2,4 give combined primary
// R10 - Eight-bit page register at base+E0h
// R11 - Page bits feed decode and logic array
// R12 - Two read-only memory identification registers
// R13 - Fast bit clear: standby after 70ns
// R14 - Five power bits block control signals
// R15 - Logic arrays share 82-signal input bus
// R16 - Extended mode uses address bits 19:4
// R17 - Primary, 4 secondary, SRAM selects decoded
// R18 - Config, JTAG, two peripheral selects decoded
// R19 - Eight external selects to port C/F
// R20 - Sixteen output cells, twenty-four input cells
// R21 - SRAM responds only while its select high
// R22 - No match: no select, bus undriven
`timescale 1ns/10ps
module msd_memory_select import msd_pkg::*; #(
    parameter logic [255:0] PRI_BASE = PRI_BASE_DEF,
    parameter logic [255:0] PRI_MASK = PRI_MASK_DEF,
    parameter logic [127:0] PRI_PAGE = PRI_PAGE_DEF,
    parameter logic [127:0] PRI_PMASK = PRI_PMASK_DEF,
    parameter logic [63:0] SEC_BASE = SEC_BASE_DEF,
    parameter logic [63:0] SEC_MASK = SEC_MASK_DEF,
    parameter logic [15:0] SRAM_BASE = SRAM_BASE_DEF,
    parameter logic [15:0] SRAM_MASK = SRAM_MASK_DEF,
    parameter logic [15:0] CFG_BASE = CFG_BASE_DEF,
    parameter logic [31:0] PER_BASE = PER_BASE_DEF,
    parameter logic [15:0] JTAG_BASE = JTAG_BASE_DEF,
    parameter logic [127:0] ECS_BASE = ECS_BASE_DEF,
    parameter logic ECS_TO_PORT_F = 1'b0,
    parameter logic [7:0] MEM_ID0 = 8'h5a, // Arbitrary value
    parameter logic [7:0] MEM_ID1 = 8'ha5  // Arbitrary value
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [19:0] host_addr_i,
    input wire logic [15:0] host_data_i,
    input wire logic [2:0] host_control_inputs_n_i,
    input wire logic host_reset_i,
    input wire logic powerdown_input_i,
    input wire logic [23:0] input_cell_pins_i,
    input wire logic [3:0] port_d_i,
    input wire logic [7:0] port_f_i,
    input wire logic flash_ready_i,
    input wire logic ext_addr_mode_i,
    output logic [15:0] primary_sector_selects_o,
    output logic [3:0] secondary_sector_selects_o,
    output logic sram_select_o,
    output logic config_select_o,
    output logic jtag_enable_o,
    output logic [1:0] periph_selects_o,
    output logic [7:0] ecs_port_c_o,
    output logic [7:0] ecs_port_f_o,
    output logic [7:0] page_bits_o,
    output logic [BUS_W-1:0] logic_input_bus_o,
    output logic [15:0] output_cell_o,
    output logic logic_standby_o,
    output logic [15:0] host_data_o,
    output logic host_data_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] acc;
        logic [7:0] page;
        logic [7:0] map;
        logic [7:0] pwr0;
        logic [7:0] pwr2;
        logic [15:0] cells;
        logic [STBY_CNT_W-1:0] stby_cnt;
        logic standby;
        logic [15:0] pri;
        logic [3:0] sec;
        logic sram;
        logic cfg;
        logic jtag;
        logic [1:0] per;
        logic [7:0] ecs;
        logic [BUS_W-1:0] bus;
        logic [15:0] dout;
        logic doe;
    } msd_state_t;

    msd_state_t q;
    msd_state_t n;

    logic [SYNC_W-1:0] pins;
    logic [15:0] arr_addr;
    logic [7:0] cfg_off;
    logic fetch_act;
    logic data_act;
    logic pri_ok;
    logic sec_ok;
    logic sram_ok;
    logic lvl1;
    logic cfg_hit;
    logic wr_take;
    logic [4:0] ctl_gated;
    logic [7:0] rd_val;

    // Window compare; the limit forces bits above the sector size into the compare
    function automatic logic win_hit(input logic [15:0] a, input logic [7:0] pg,
                                     input logic [15:0] base, input logic [15:0] mask,
                                     input logic [7:0] pv, input logic [7:0] pm,
                                     input logic [15:0] limit);
        win_hit = (((a ^ base) & (mask | limit)) == 16'h0000)
                  && (((pg ^ pv) & pm) == 8'h00); // see R01
    endfunction : win_hit

    assign pins = {ext_addr_mode_i, flash_ready_i, port_f_i, port_d_i, input_cell_pins_i,
                   powerdown_input_i, host_reset_i, host_control_inputs_n_i,
                   host_data_i, host_addr_i};

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n = q;
        // Three-stage sync; a pin change is accepted only when stages 2 and 3 agree
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.acc[i] = q.s3[i];
            end
        end
        // Array address view depends on processor mode
        arr_addr = q.acc[S_EXT] ? q.acc[S_ADDR+4 +: 16] : q.acc[S_ADDR +: 16]; // see R16
        cfg_off = q.acc[S_ADDR +: 8];
        fetch_act = !q.acc[S_FETCH];
        data_act = !q.acc[S_RD] || !q.acc[S_WR];
        // Space mapping: 0Ch gives fetch-only primary, data for the rest
        pri_ok = (fetch_act && q.map[MAP_PRI_FETCH])
                 || (data_act && q.map[MAP_PRI_DATA]); // see R07 see R08 see R09
        sec_ok = (fetch_act && q.map[MAP_SEC_FETCH]) || (data_act && q.map[MAP_SEC_DATA]);
        sram_ok = (fetch_act && q.map[MAP_SRAM_FETCH]) || data_act;
        // Level one targets: SRAM, configuration, peripherals, JTAG
        n.sram = sram_ok && win_hit(arr_addr, q.page, SRAM_BASE, SRAM_MASK,
                                    8'h00, 8'h00, SRAM_LIMIT); // see R17 see R21
        n.cfg = data_act && win_hit(arr_addr, 8'h00, CFG_BASE, IO_MASK_DEF,
                                    8'h00, 8'h00, 16'h0000); // see R18
        n.jtag = data_act && win_hit(arr_addr, 8'h00, JTAG_BASE, IO_MASK_DEF,
                                     8'h00, 8'h00, 16'h0000); // see R18
        for (int i = 0; i < 2; i++) begin
            n.per[i] = data_act && win_hit(arr_addr, 8'h00, PER_BASE[i*16 +: 16],
                                           IO_MASK_DEF, 8'h00, 8'h00, 16'h0000);
        end
        lvl1 = n.sram || n.cfg || n.jtag || (|n.per);
        // Flash levels, page bits take part in the primary compare only
        for (int i = 0; i < 4; i++) begin
            n.sec[i] = sec_ok && !lvl1 && win_hit(arr_addr, q.page, SEC_BASE[i*16 +: 16],
                       SEC_MASK[i*16 +: 16], 8'h00, 8'h00, SEC_LIMIT); // see R03 see R06
        end
        for (int i = 0; i < 16; i++) begin
            n.pri[i] = pri_ok && !lvl1 && !(|n.sec)
                       && win_hit(arr_addr, q.page, PRI_BASE[i*16 +: 16],
                                  PRI_MASK[i*16 +: 16], PRI_PAGE[i*8 +: 8],
                                  PRI_PMASK[i*8 +: 8], PRI_LIMIT); // see R02 see R04 see R05
        end
        // External selects from the general array, no output cell used
        for (int i = 0; i < 8; i++) begin
            n.ecs[i] = win_hit(arr_addr, 8'h00, ECS_BASE[i*16 +: 16], IO_MASK_DEF,
                               8'h00, 8'h00, 16'h0000); // see R19
        end
        // Register writes land on the trailing edge of the write strobe
        cfg_hit = q.cfg;
        wr_take = cfg_hit && !q.acc[S_WR] && n.acc[S_WR];
        if (wr_take) begin
            case (cfg_off)
                OFF_PAGE: n.page = q.acc[S_DATA +: 8]; // see R10
                OFF_MAP: n.map = q.acc[S_DATA +: 8]; // see R07
                OFF_PWR0: n.pwr0 = q.acc[S_DATA +: 8];
                OFF_PWR2: n.pwr2 = q.acc[S_DATA +: 8];
                OFF_CELL_A: n.cells[7:0] = q.acc[S_DATA +: 8]; // see R20
                OFF_CELL_B: n.cells[15:8] = q.acc[S_DATA +: 8];
                default: n.cells = q.cells;
            endcase
        end
        // Read mux; ID registers are fixed and ignore writes
        case (cfg_off)
            OFF_PAGE: rd_val = q.page; // see R10
            OFF_MAP: rd_val = q.map;
            OFF_PWR0: rd_val = q.pwr0;
            OFF_PWR2: rd_val = q.pwr2;
            OFF_ID0: rd_val = MEM_ID0; // see R12
            OFF_ID1: rd_val = MEM_ID1; // see R12
            OFF_CELL_A: rd_val = q.cells[7:0];
            OFF_CELL_B: rd_val = q.cells[15:8];
            default: rd_val = 8'h00;
        endcase
        // Bus is driven only for a config read; otherwise left floating
        n.doe = n.cfg && !q.acc[S_RD]; // see R22
        n.dout = {8'h00, rd_val};
        // Power bits force blocked controls inactive toward the arrays
        ctl_gated = {q.acc[S_PDN] & ~q.pwr2[4], q.acc[S_HRST] & ~q.pwr2[3],
                     q.acc[S_FETCH] | q.pwr2[2], q.acc[S_RD] | q.pwr2[1],
                     q.acc[S_WR] | q.pwr2[0]}; // see R14
        n.bus = {q.acc[S_RDY], q.cells[15:8], q.cells[7:0], q.page,
                 q.acc[S_PF +: 8], q.acc[S_PD +: 4], q.acc[S_ABC +: 24],
                 ctl_gated, arr_addr}; // see R15 see R11 see R20
        // Standby once the input bus has sat still long enough, fast bit clear
        if ((n.bus != q.bus) || q.pwr0[PWR0_FAST]) begin
            n.stby_cnt = '0;
            n.standby = 1'b0;
        end else if (q.stby_cnt < STBY_CNT_W'(STBY_CYC)) begin
            n.stby_cnt = q.stby_cnt + STBY_CNT_W'(1);
            n.standby = 1'b0;
        end else begin
            n.standby = 1'b1; // see R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; pin stages reset to an idle bus
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.s1[S_WR +: 3] <= 3'h7;
            q.s2[S_WR +: 3] <= 3'h7;
            q.s3[S_WR +: 3] <= 3'h7;
            q.acc[S_WR +: 3] <= 3'h7;
            q.page <= PAGE_RST;
            q.map <= MAP_RST;
            q.pwr0 <= PWR0_RST;
            q.pwr2 <= PWR2_RST;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign primary_sector_selects_o = q.pri;
    assign secondary_sector_selects_o = q.sec;
    assign sram_select_o = q.sram;
    assign config_select_o = q.cfg;
    assign jtag_enable_o = q.jtag;
    assign periph_selects_o = q.per;
    assign ecs_port_c_o = ECS_TO_PORT_F ? 8'h00 : q.ecs;
    assign ecs_port_f_o = ECS_TO_PORT_F ? q.ecs : 8'h00;
    assign page_bits_o = q.page;
    assign logic_input_bus_o = q.bus;
    assign output_cell_o = q.cells;
    assign logic_standby_o = q.standby;
    assign host_data_o = q.dout;
    assign host_data_oe_o = q.doe;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_pri_excl;
        $onehot0(primary_sector_selects_o);
    endproperty
    a_pri_excl: assert property (p_pri_excl) else $error("two primary selects"); // see R02

    property p_sec_excl;
        $onehot0(secondary_sector_selects_o);
    endproperty
    a_sec_excl: assert property (p_sec_excl) else $error("two secondary selects"); // see R03

    property p_sec_wins;
        (|secondary_sector_selects_o) |-> (primary_sector_selects_o == 16'h0000);
    endproperty
    a_sec_wins: assert property (p_sec_wins) else $error("primary beside secondary"); // see R04

    property p_lvl1_excl;
        $onehot0({sram_select_o, config_select_o, jtag_enable_o, periph_selects_o});
    endproperty
    a_lvl1_excl: assert property (p_lvl1_excl) else $error("level one overlap"); // see R05

    property p_lvl1_wins;
        (sram_select_o || config_select_o || (|periph_selects_o))
            |-> !(|primary_sector_selects_o) && !(|secondary_sector_selects_o);
    endproperty
    a_lvl1_wins: assert property (p_lvl1_wins) else $error("flash beside level one"); // see R06

    property p_page_write;
        (wr_take && cfg_off == OFF_PAGE) |=> (page_bits_o == $past(q.acc[S_DATA +: 8]));
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost"); // see R10

    property p_fast_no_stby;
        q.pwr0[PWR0_FAST] |=> !logic_standby_o;
    endproperty
    a_fast_no_stby: assert property (p_fast_no_stby) else $error("standby in fast mode"); // see R13

    property p_stby_time;
        $rose(logic_standby_o) |-> $past(logic_input_bus_o, 8) == logic_input_bus_o;
    endproperty
    a_stby_time: assert property (p_stby_time) else $error("standby too early"); // see R13

    property p_quiet;
        host_data_oe_o |-> config_select_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus driven without select"); // see R22

    property p_map_fetch;
        (q.map == 8'h0c && !q.acc[S_FETCH] && q.acc[S_RD] && q.acc[S_WR])
            |=> !sram_select_o && !(|secondary_sector_selects_o);
    endproperty
    a_map_fetch: assert property (p_map_fetch) else $error("data memory on fetch"); // see R08

    c_sram: cover property (sram_select_o);
    c_sec_over_pri: cover property (|secondary_sector_selects_o);
    c_page_wr: cover property (wr_take && cfg_off == OFF_PAGE);
    c_standby: cover property ($rose(logic_standby_o));

endmodule : msd_memory_select

// file: msd_host_model.sv
// Host bus model: microcontroller driving address, data and strobes
`timescale 1ns/10ps
module msd_host_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rdata_oe_i,
    output logic [19:0] addr_o,
    output logic [15:0] wdata_o,
    output logic [2:0] ctrl_n_o
);
    // Pins are synchronised inside, so every phase is held well past six cycles
    localparam int HOLD = 8;

    // Idle bus at time zero
    initial begin
        addr_o = 20'h00000;
        wdata_o = 16'h0000;
        ctrl_n_o = 3'h7;
    end

    // New bus state just after an edge, then held for the hold time
    task automatic put(input logic [19:0] a, input logic [15:0] d, input logic [2:0] c);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        ctrl_n_o <= c;
        repeat (HOLD) @(posedge clk_i);
    endtask : put

    // Write cycle; data is released after the trailing edge
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        logic [15:0] w;
        w = {8'($urandom), d};
        put(a, w, 3'h6);
        put(a, w, 3'h7);
        put(a, ~w, 3'h7); // Released data must not keep its last value
    endtask : wr

    // Read cycle; answer taken at the last held edge
    task automatic rd(input logic [19:0] a, output logic [15:0] d, output logic oe);
        put(a, ~wdata_o, 3'h5);
        d = rdata_i;
        oe = rdata_oe_i;
        put(a, ~wdata_o, 3'h7);
    endtask : rd
endmodule : msd_host_model

// file: tb_top.sv
// Self-checking testbench for the memory select decode block
`timescale 1ns/10ps
module tb_top;
    import msd_pkg::*;
    localparam logic [7:0] ID0 = 8'h3c; // Arbitrary value
    localparam logic [7:0] ID1 = 8'hc3; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hrst = 1'b0, powerdown_input = 1'b0, rdy = 1'b0, ext = 1'b0;
    logic [23:0] cells = 24'h000000;
    logic [3:0] pd = 4'h0;
    logic [7:0] pf = 8'h00;
    logic [19:0] addr;
    logic [15:0] wdat, pri, rdat, cello;
    logic [2:0] ctl;
    logic [3:0] sec;
    logic sram, cfg, jtag, stby, oe;
    logic [1:0] per;
    logic [7:0] ecs_c, ecs_f, page, map_q, page_q;
    logic [BUS_W-1:0] ibus;
    int n_mismatch = 0, n_tests = 0, cyc = 0;

    // Secondary 0 moved over primary, SRAM moved over flash, to exercise priority
    msd_memory_select #(.SEC_BASE(64'h7000600050009000), .SRAM_BASE(16'ha000),
        .MEM_ID0(ID0), .MEM_ID1(ID1)) i_msd_memory_select (
        .clk_sys_i(clk), .rst_i(rst), .host_addr_i(addr), .host_data_i(wdat),
        .host_control_inputs_n_i(ctl), .host_reset_i(hrst), .powerdown_input_i(powerdown_input),
        .input_cell_pins_i(cells), .port_d_i(pd), .port_f_i(pf), .flash_ready_i(rdy),
        .ext_addr_mode_i(ext), .primary_sector_selects_o(pri),
        .secondary_sector_selects_o(sec), .sram_select_o(sram), .config_select_o(cfg),
        .jtag_enable_o(jtag), .periph_selects_o(per), .ecs_port_c_o(ecs_c),
        .ecs_port_f_o(ecs_f), .page_bits_o(page), .logic_input_bus_o(ibus),
        .output_cell_o(cello), .logic_standby_o(stby), .host_data_o(rdat),
        .host_data_oe_o(oe));
    msd_host_model i_msd_host_model (.clk_i(clk), .rdata_i(rdat), .rdata_oe_i(oe),
        .addr_o(addr), .wdata_o(wdat), .ctrl_n_o(ctl));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Hang guard; the whole run needs about 5000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end

    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [19:0] cfga(input logic [7:0] off);
        return {4'h0, CFG_BASE_DEF[15:8], off};
    endfunction : cfga

    // Expected {oe, periph, jtag, config, sram, secondary, primary}
    function automatic logic [31:0] exp_sel(input logic [15:0] a, input logic [2:0] c,
        input logic [7:0] pg, input logic [7:0] mp);
        logic rd;
        logic fe;
        logic dsp;
        logic [31:0] r;
        rd = !c[1];
        fe = !c[2];
        dsp = rd || !c[0];
        r = 32'h0;
        r[20] = (dsp || (fe && mp[MAP_SRAM_FETCH])) && a[15:13] == 3'h5;
        r[21] = dsp && a[15:8] == 8'h20;
        r[22] = dsp && a[15:8] == 8'h23;
        r[23] = dsp && a[15:8] == 8'h21;
        r[24] = dsp && a[15:8] == 8'h22;
        r[25] = rd && r[21];
        // Level one beats flash, secondary beats primary
        if (r[24:20] == 5'h0 && ((fe && mp[MAP_SEC_FETCH]) || (rd && mp[MAP_SEC_DATA]))) begin
            if (a[15:12] == 4'h9) begin
                r[16] = 1'b1;
            end else if (a[15:14] == 2'b01 && a[13:12] != 2'h0) begin
                r[16 + a[13:12]] = 1'b1;
            end
        end
        if (r[24:16] == 9'h0 && a[15] && pg < 8'h10
            && ((fe && mp[MAP_PRI_FETCH]) || (rd && mp[MAP_PRI_DATA]))) begin
            r[pg[3:0]] = 1'b1;
        end
        return r;
    endfunction : exp_sel

    ////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] d, a;
        logic ok;
        logic [7:0] v;
        logic [2:0] c;
        logic [19:0] a20;
        logic [7:0] maps [4] = '{8'h0c, 8'h14, 8'h1b, 8'h00};
        logic [15:0] corner [4] = '{16'h9000, 16'ha000, 16'h23ff, 16'h3500};
        void'($urandom(86418));
        map_q = MAP_RST;
        page_q = PAGE_RST;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(page, PAGE_RST, "page reset");
        check({oe, per, jtag, cfg, sram, sec, pri}, 32'h0, "selects reset");
        i_msd_host_model.rd(cfga(OFF_MAP), d, ok);
        check(d, MAP_RST, "map reset");
        for (int i = 0; i < 2; i++) begin
            v = i ? ID1 : ID0;
            i_msd_host_model.wr(cfga(i ? OFF_ID1 : OFF_ID0), ~v);
            i_msd_host_model.rd(cfga(i ? OFF_ID1 : OFF_ID0), d, ok);
            check({ok, d}, {1'b1, 8'h00, v}, "id read");
        end
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            i_msd_host_model.wr(cfga(OFF_PAGE), v);
            check(page, v, "page bits");
            check(ibus[64:57], v, "page on bus");
            i_msd_host_model.rd(cfga(OFF_PAGE), d, ok);
            check({ok, d}, {1'b1, 8'h00, v}, "page read");
            page_q = v;
        end
        // Output cells are host-loadable and fed back onto the array bus
        i_msd_host_model.wr(cfga(OFF_CELL_A), v);
        i_msd_host_model.wr(cfga(OFF_CELL_B), ~v);
        check({cello, ibus[80:65]}, {~v, v, ~v, v}, "output cells");
        i_msd_host_model.rd(cfga(OFF_CELL_B), d, ok);
        check({ok, d}, {1'b1, 8'h00, ~v}, "cell read");
        $display("test registers done");
        // Input bus makeup in both address modes
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            ext <= i[0];
            cells <= 24'($urandom);
            pd <= 4'($urandom);
            pf <= 8'($urandom);
            rdy <= 1'($urandom);
            hrst <= 1'($urandom);
            powerdown_input <= 1'($urandom);
            a20 = 20'($urandom);
            i_msd_host_model.put(a20, ~wdat, 3'h7);
            check(ibus[15:0], i ? a20[19:4] : a20[15:0], "array address");
            check({ibus[81], ibus[56:19]}, {rdy, pf, pd, cells, powerdown_input, hrst}, "bus");
            check(ibus[64:57], page_q, "page field");
        end
        @(posedge clk);
        hrst <= 1'b0;
        powerdown_input <= 1'b0;
        $display("test input bus done");
        // Decode trials: corner addresses first, then random
        for (int i = 0; i < 160; i++) begin
            if (i % 10 == 0) begin
                map_q = maps[(i / 10) % 4];
                i_msd_host_model.wr(cfga(OFF_MAP), map_q);
            end
            if (i % 5 == 0) begin
                page_q = (i == 0) ? 8'h00 : 8'($urandom % 20);
                i_msd_host_model.wr(cfga(OFF_PAGE), page_q);
            end
            a = (i < 4) ? corner[i] : 16'($urandom);
            c = (i < 4 || $urandom % 2) ? 3'h5 : 3'h3;
            if (c == 3'h3 && a[15:10] == 6'h08) begin
                a = a ^ 16'h4000;
            end
            i_msd_host_model.put({4'h0, a}, ~wdat, c);
            check({oe, per, jtag, cfg, sram, sec, pri}, exp_sel(a, c, page_q, map_q),
                "decode");
            check(ecs_f, 8'h00, "unused select port");
            // External selects decode the high address byte only, no strobe needed
            for (int k = 0; k < 8; k++) begin
                v[k] = (a[15:8] == ECS_BASE_DEF[k*16+8 +: 8]);
            end
            check(ecs_c, v, "external selects");
            i_msd_host_model.put({4'h0, a}, ~wdat, 3'h7);
            check({oe, per, jtag, cfg, sram, sec, pri}, 32'h0, "no strobe");
        end
        $display("test decode done");
        // Standby follows the fast bit and input activity
        repeat (24) @(posedge clk);
        check(stby, 1'b1, "standby idle");
        i_msd_host_model.put(20'h03c00, ~wdat, 3'h7);
        check(stby, 1'b0, "standby wake");
        i_msd_host_model.wr(cfga(OFF_PWR0), 8'h08);
        repeat (24) @(posedge clk);
        check(stby, 1'b0, "fast mode");
        $display("test standby done");
        // Each blocking bit forces its signal to the inactive level
        for (int b = 4; b >= 0; b--) begin
            i_msd_host_model.wr(cfga(OFF_PWR2), 8'(1 << b));
            @(posedge clk);
            hrst <= (b == 3);
            powerdown_input <= (b == 4);
            i_msd_host_model.put(20'h03c00, ~wdat, (b < 3) ? ~3'(1 << b) : 3'h7);
            check(ibus[16 + b], b < 3, "blocked signal");
            i_msd_host_model.put(20'h03c00, ~wdat, 3'h7);
            hrst <= 1'b0;
            powerdown_input <= 1'b0;
        end
        // Mid-run reset restores the registers
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(page, PAGE_RST, "page after reset");
        i_msd_host_model.rd(cfga(OFF_MAP), d, ok);
        check(d, MAP_RST, "map after reset");
        $display("test blocking done");
        wrap_up();
    end
endmodule : tb_top
